// *** dsm_defines.vh ***
`ifndef DSM_DEFINES_VH
`define DSM_DEFINES_VH
// Word addresses of the status monitor range
`define DSM_ADDR_FAULT      16'h2100
`define DSM_ADDR_STATE      16'h2101
`define DSM_ADDR_FREQ_CMD   16'h2102
`define DSM_ADDR_OUT_FREQ   16'h2103
`define DSM_ADDR_OUT_CUR    16'h2104
`define DSM_ADDR_RSVD_A     16'h2105
`define DSM_ADDR_PID_FB     16'h2106
`define DSM_ADDR_RSVD_B     16'h2107
`define DSM_ADDR_BUS_VOLT   16'h2108
`define DSM_ADDR_OUT_VOLT   16'h2109
`define DSM_ADDR_STAGE_TEMP 16'h210A
`define DSM_ADDR_USER_LO    16'h2116
`define DSM_ADDR_USER_HI    16'h2117
// Fault codes
`define DSM_FC_NONE         6'h00
`define DSM_FC_OVERCURRENT  6'h01
`define DSM_FC_OVERVOLTAGE  6'h02
`define DSM_FC_STAGE_HOT    6'h03
`define DSM_FC_OVERLOAD     6'h05
`define DSM_FC_OVERLOAD1    6'h06
`define DSM_FC_OVERLOAD2    6'h07
`define DSM_FC_EXTERNAL     6'h08
`define DSM_FC_OC_ACCEL     6'h09
`define DSM_FC_OC_DECEL     6'h0A
`define DSM_FC_OC_STEADY    6'h0B
`define DSM_FC_GROUND       6'h0C
`define DSM_FC_PHASE_LOSS   6'h0E
`define DSM_FC_RAMP_TUNE    6'h10
`define DSM_FC_SW_PROTECT   6'h11
`define DSM_FC_PB_WRITE     6'h12
`define DSM_FC_PB_READ      6'h13
`define DSM_FC_HW_BASE      6'h14
`define DSM_FC_PHASE_BASE   6'h18
`define DSM_FC_LOOP_INPUT   6'h20
`define DSM_FC_THERMISTOR   6'h22
// Number of fault flag slots: 27 fault sources and one spare
`define DSM_NUM_FAULTS      28
// Status word field positions
`define DSM_ST_RUN_LSB      0
`define DSM_ST_JOG          2
`define DSM_ST_DIR_LSB      3
`define DSM_ST_FREQ_COMM    8
`define DSM_ST_FREQ_ANALOG  9
`define DSM_ST_OPER_COMM    10
// Reset value of every captured word
`define DSM_WORD_RESET      16'h0000
`endif

// *** dsm_sync.v ***
`timescale 1ns/1ps
// Two-flop synchroniser, one per bit
module dsm_sync #(
   parameter W = 1
) (
   // Clock and reset
   input  wire         clk,
   input  wire         rst_n,
   // Data
   input  wire [W-1:0] d,
   output wire [W-1:0] q
);
   reg [W-1:0] meta_q;  // First stage, read only by second stage
   reg [W-1:0] sync_q;  // Second stage
   genvar i;
   // One synchroniser per bit
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         always @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               meta_q[i] <= 1'b0;
               sync_q[i] <= 1'b0;
            end else begin
               meta_q[i] <= d[i];
               sync_q[i] <= meta_q[i];
            end
         end
      end
   endgenerate
   assign q = sync_q;
endmodule

// *** dsm_fault_encoder.v ***
`timescale 1ns/1ps
`include "dsm_defines.vh"
// Priority encoder from fault flags to a fault code
module dsm_fault_encoder (
   // Fault flags, bit order fixed by the top
   input  wire [`DSM_NUM_FAULTS-1:0] flags,
   // Code of lowest-index active flag, zero if none
   output reg  [5:0]                 code
);
   wire [5:0] code_tab [0:`DSM_NUM_FAULTS-1];  // Code per flag slot
   integer k;
   // Constant table; reserved codes never appear in it
   // Nets, since a combinational process that reads nothing never wakes up
   assign code_tab[0]  = `DSM_FC_OVERCURRENT;
   assign code_tab[1]  = `DSM_FC_OVERVOLTAGE;
   assign code_tab[2]  = `DSM_FC_STAGE_HOT;
   assign code_tab[3]  = `DSM_FC_OVERLOAD;
   assign code_tab[4]  = `DSM_FC_OVERLOAD1;
   assign code_tab[5]  = `DSM_FC_OVERLOAD2;
   assign code_tab[6]  = `DSM_FC_EXTERNAL;
   assign code_tab[7]  = `DSM_FC_OC_ACCEL;
   assign code_tab[8]  = `DSM_FC_OC_DECEL;
   assign code_tab[9]  = `DSM_FC_OC_STEADY;
   assign code_tab[10] = `DSM_FC_GROUND;
   assign code_tab[11] = `DSM_FC_PHASE_LOSS;
   assign code_tab[12] = `DSM_FC_RAMP_TUNE;
   assign code_tab[13] = `DSM_FC_SW_PROTECT;
   assign code_tab[14] = `DSM_FC_PB_WRITE;
   assign code_tab[15] = `DSM_FC_PB_READ;
   assign code_tab[16] = `DSM_FC_HW_BASE;
   assign code_tab[17] = `DSM_FC_HW_BASE + 6'h01;
   assign code_tab[18] = `DSM_FC_HW_BASE + 6'h02;
   assign code_tab[19] = `DSM_FC_HW_BASE + 6'h03;
   assign code_tab[20] = `DSM_FC_PHASE_BASE;
   assign code_tab[21] = `DSM_FC_PHASE_BASE + 6'h01;
   assign code_tab[22] = `DSM_FC_PHASE_BASE + 6'h02;
   assign code_tab[23] = `DSM_FC_PHASE_BASE + 6'h03;
   assign code_tab[24] = `DSM_FC_PHASE_BASE + 6'h04;
   assign code_tab[25] = `DSM_FC_LOOP_INPUT;
   assign code_tab[26] = `DSM_FC_THERMISTOR;
   assign code_tab[27] = `DSM_FC_NONE;
   // Scan high to low so the lowest index wins
   always @* begin
      code = `DSM_FC_NONE;
      for (k = `DSM_NUM_FAULTS - 2; k >= 0; k = k - 1) begin
         if (flags[k]) begin
            code = code_tab[k];
         end
      end
   end
endmodule

// *** dsm_monitor_regs.v ***
`timescale 1ns/1ps
`include "dsm_defines.vh"
module dsm_monitor_regs (
   // Clock and reset
   input  wire        clk,
   input  wire        arst_n,
   // Read and write requests from the serial slave front end, and the answers to it
   input  wire        rd_start,
   input  wire        rd_req,
   input  wire [15:0] rd_addr,
   input  wire        wr_req,
   output reg         rd_valid,
   output reg  [15:0] rd_data,
   output reg         rd_illegal,
   output reg         wr_refused,
   // Fault sources from the drive, asynchronous levels
   input  wire        overcurrent_fault,
   input  wire        overvoltage_fault,
   input  wire        stage_overheat_fault,
   input  wire        overload_fault,
   input  wire        overload1_fault,
   input  wire        overload2_fault,
   input  wire        external_fault,
   input  wire        accel_overcurrent,
   input  wire        decel_overcurrent,
   input  wire        steady_overcurrent,
   input  wire        ground_fault,
   input  wire        phase_loss,
   input  wire        ramp_tune_failure,
   input  wire        sw_protect_active,
   input  wire        pb_write_failure,
   input  wire        pb_read_failure,
   input  wire [3:0]  hw_protect_failure,
   input  wire        u_phase_error,
   input  wire        v_phase_error,
   input  wire        w_phase_error,
   input  wire        dc_bus_error,
   input  wire        phase_check_overheat,
   input  wire        loop_input_error,
   input  wire        thermistor_overheat,
   // Drive state, same clock domain
   input  wire [1:0]  run_state,
   input  wire        jog_active,
   input  wire [1:0]  direction_state,
   input  wire        freq_from_comm,
   input  wire        freq_from_analog,
   input  wire        oper_from_comm,
   // Measurements, same clock domain
   input  wire [15:0] freq_command,
   input  wire [15:0] output_frequency,
   input  wire [15:0] output_current,
   input  wire [15:0] pid_feedback,
   input  wire [15:0] bus_voltage,
   input  wire [15:0] output_voltage,
   input  wire [15:0] power_stage_temp,
   input  wire [15:0] user_display_value,
   input  wire [7:0]  user_display_decimals,
   input  wire [7:0]  user_display_letter
);
   localparam NW = 13;                     // Captured words
   reg  [1:0]  rst_sync_q;                 // Reset release chain
   wire        rst_n;                      // Synchronised reset
   wire [`DSM_NUM_FAULTS-1:0] flags_raw;   // Fault pins as gathered
   wire [`DSM_NUM_FAULTS-1:0] flags_sync;  // After two flops
   wire [5:0]  fault_code;                 // Encoded current fault
   wire [15:0] live [0:NW-1];              // Live source words
   reg  [15:0] snap_q [0:NW-1];            // Coherent snapshot
   reg  [3:0]  idx;                        // Decoded word index
   reg         hit;                        // Address is mapped
   reg  [15:0] state_word;                 // Assembled status word
   integer     n;

   // Reset is released through two flops; assertion stays asynchronous
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // Fault pins in encoder slot order; last slot is a spare
   assign flags_raw = {1'b0,
                       thermistor_overheat,
                       loop_input_error,
                       phase_check_overheat, dc_bus_error,
                       w_phase_error, v_phase_error, u_phase_error,
                       hw_protect_failure[3], hw_protect_failure[2],
                       hw_protect_failure[1], hw_protect_failure[0],
                       pb_read_failure, pb_write_failure,
                       sw_protect_active,
                       ramp_tune_failure, phase_loss, ground_fault,
                       steady_overcurrent, decel_overcurrent,
                       accel_overcurrent,
                       external_fault, overload2_fault, overload1_fault,
                       overload_fault, stage_overheat_fault,
                       overvoltage_fault, overcurrent_fault};

   // Fault pins come from outside and are synchronised first
   dsm_sync #(
      .W (`DSM_NUM_FAULTS)
   ) u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     (flags_raw),
      .q     (flags_sync)
   );

   // Lowest slot wins when several faults stand at once
   dsm_fault_encoder u_enc (
      .flags (flags_sync),
      .code  (fault_code)
   );

   // Status word; reserved bits forced to zero
   always @* begin
      state_word = 16'h0000;
      state_word[`DSM_ST_RUN_LSB +: 2] = run_state;
      state_word[`DSM_ST_JOG]          = jog_active;
      state_word[`DSM_ST_DIR_LSB +: 2] = direction_state;
      state_word[`DSM_ST_FREQ_COMM]    = freq_from_comm;
      state_word[`DSM_ST_FREQ_ANALOG]  = freq_from_analog;
      state_word[`DSM_ST_OPER_COMM]    = oper_from_comm;
   end

   // Live word table in snapshot index order
   assign live[0]  = {10'h000, fault_code};
   assign live[1]  = state_word;
   assign live[2]  = freq_command;
   assign live[3]  = output_frequency;
   assign live[4]  = output_current;
   assign live[5]  = pid_feedback;
   assign live[6]  = bus_voltage;
   assign live[7]  = output_voltage;
   assign live[8]  = power_stage_temp;
   assign live[9]  = user_display_value;
   assign live[10] = {user_display_decimals, user_display_letter};
   assign live[11] = `DSM_WORD_RESET;
   assign live[12] = `DSM_WORD_RESET;

   // Address decode; reserved words map to the zero slots
   always @* begin
      idx = 4'h0;
      hit = 1'b1;
      case (rd_addr)
         `DSM_ADDR_FAULT:      idx = 4'h0;
         `DSM_ADDR_STATE:      idx = 4'h1;
         `DSM_ADDR_FREQ_CMD:   idx = 4'h2;
         `DSM_ADDR_OUT_FREQ:   idx = 4'h3;
         `DSM_ADDR_OUT_CUR:    idx = 4'h4;
         `DSM_ADDR_RSVD_A:     idx = 4'hB;
         `DSM_ADDR_PID_FB:     idx = 4'h5;
         `DSM_ADDR_RSVD_B:     idx = 4'hC;
         `DSM_ADDR_BUS_VOLT:   idx = 4'h6;
         `DSM_ADDR_OUT_VOLT:   idx = 4'h7;
         `DSM_ADDR_STAGE_TEMP: idx = 4'h8;
         `DSM_ADDR_USER_LO:    idx = 4'h9;
         `DSM_ADDR_USER_HI:    idx = 4'hA;
         default: begin
            idx = 4'h0;
            hit = 1'b0;
         end
      endcase
   end

   // Snapshot all words at once so a multi-word read is coherent
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (n = 0; n < NW; n = n + 1) begin
            snap_q[n] <= `DSM_WORD_RESET;
         end
      end else if (rd_start) begin
         for (n = 0; n < NW; n = n + 1) begin
            snap_q[n] <= live[n];
         end
      end
   end

   // Read answer one cycle after the request, from the snapshot
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_valid   <= 1'b0;
         rd_data    <= `DSM_WORD_RESET;
         rd_illegal <= 1'b0;
         wr_refused <= 1'b0;
      end else begin
         rd_valid   <= rd_req;
         rd_illegal <= rd_req & ~hit;
         // Writes change nothing here; flag them for an exception reply
         wr_refused <= wr_req;
         if (rd_req) begin
            // Unmapped words answer zero and raise the illegal flag
            rd_data <= hit ? snap_q[idx] : `DSM_WORD_RESET;
         end
      end
   end
endmodule

// *** dsm_monitor_regs_props.sv ***
`timescale 1ns/1ps
module dsm_monitor_regs_props (
   // Clock and reset
   input wire logic        clk,
   input wire logic        arst_n,
   // Read handshake
   input wire logic        rd_req,
   input wire logic [15:0] rd_addr,
   input wire logic        rd_valid,
   input wire logic [15:0] rd_data,
   input wire logic        rd_illegal,
   // Write refusal
   input wire logic        wr_req,
   input wire logic        wr_refused
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   // Mapped words, the two reserved holes included
   function automatic logic mapped(input logic [15:0] a);
      return (a >= 16'h2100 && a <= 16'h210A) || a == 16'h2116 || a == 16'h2117;
   endfunction
   // Fault word: only documented codes, upper bits clear
   function automatic logic code_ok(input logic [15:0] d);
      return d[15:6] == 10'h000 && d[5:0] <= 6'h22 &&
             !(d[5:0] inside {6'h04, 6'h0D, 6'h0F, 6'h1D, 6'h1E, 6'h1F, 6'h21});
   endfunction
   property p_valid_lat;
      rd_req |=> rd_valid;
   endproperty
   a_valid_lat: assert property (p_valid_lat) else $error("read answer late");
   property p_valid_cause;
      rd_valid |-> $past(rd_req);
   endproperty
   a_valid_cause: assert property (p_valid_cause) else $error("answer without read");
   property p_illegal;
      rd_valid |-> rd_illegal == !mapped($past(rd_addr));
   endproperty
   a_illegal: assert property (p_illegal) else $error("illegal flag wrong");
   property p_ill_zero;
      rd_illegal |-> rd_valid && rd_data == 16'h0000;
   endproperty
   a_ill_zero: assert property (p_ill_zero) else $error("illegal read not zero");
   property p_rsvd;
      rd_valid && ($past(rd_addr) == 16'h2105 || $past(rd_addr) == 16'h2107)
         |-> rd_data == 16'h0000;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved word not zero");
   property p_fault;
      rd_valid && $past(rd_addr) == 16'h2100 |-> code_ok(rd_data);
   endproperty
   a_fault: assert property (p_fault) else $error("bad fault code");
   property p_state;
      rd_valid && $past(rd_addr) == 16'h2101 |-> rd_data[7:5] == 3'h0 && rd_data[15:11] == 5'h00;
   endproperty
   a_state: assert property (p_state) else $error("status reserved bits set");
   property p_hold;
      !rd_valid |-> $stable(rd_data);
   endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_wr_refuse;
      wr_req |=> wr_refused;
   endproperty
   a_wr_refuse: assert property (p_wr_refuse) else $error("write not refused");
   property p_wr_cause;
      wr_refused |-> $past(wr_req);
   endproperty
   a_wr_cause: assert property (p_wr_cause) else $error("refusal without write");
   property p_wr_inert;
      wr_req && !rd_req |=> $stable(rd_data);
   endproperty
   a_wr_inert: assert property (p_wr_inert) else $error("write moved read data");
endmodule
bind dsm_monitor_regs dsm_monitor_regs_props i_props (.clk(clk), .arst_n(arst_n),
   .rd_req(rd_req), .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_data(rd_data),
   .rd_illegal(rd_illegal), .wr_req(wr_req), .wr_refused(wr_refused));

// *** dsm_master_model.sv ***
`timescale 1ns/1ps
// Polling master: snapshot, then single-word reads
module dsm_master_model (
   // Clock
   input wire logic         clk,
   // Requests
   output logic             rd_start,
   output logic             rd_req,
   output logic      [15:0] rd_addr,
   output logic             wr_req,
   // Answers
   input wire logic         rd_valid,
   input wire logic  [15:0] rd_data,
   input wire logic         rd_illegal,
   input wire logic         wr_refused
);
   // Idle at time zero
   initial begin
      rd_start = 1'b0;
      rd_req = 1'b0;
      rd_addr = 16'h0000;
      wr_req = 1'b0;
   end
   // Freeze all words before a frame
   task automatic snap();
      @(negedge clk);
      rd_start = 1'b1;
      @(negedge clk);
      rd_start = 1'b0;
   endtask
   // Answer stands one cycle after the request edge
   task automatic read(input logic [15:0] a, output logic [15:0] d, output logic il,
                       output logic ok);
      @(negedge clk);
      rd_req = 1'b1;
      rd_addr = a;
      @(negedge clk);
      rd_req = 1'b0;
      rd_addr = ~a; // Released address shows garbage, not the last value
      ok = rd_valid;
      d = rd_data;
      il = rd_illegal;
   endtask
   // Only for the refusal check; normal polling never writes here
   task automatic poke(output logic rf);
      @(negedge clk);
      wr_req = 1'b1;
      @(negedge clk);
      wr_req = 1'b0;
      rf = wr_refused;
   endtask
endmodule

// *** tb_dsm_monitor_regs.sv ***
`timescale 1ns/1ps
`define DSM_CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin err_total++; \
   $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_dsm_monitor_regs;
   logic        clk, arst_n, rd_start, rd_req, wr_req, rd_valid, rd_illegal, wr_refused, rf;
   logic [15:0] rd_addr, rd_data;
   logic [26:0] flt;       // Fault levels, in code order
   logic [10:0] st;        // Drive state fields
   logic [15:0] m [0:8];   // Measurements, last one is decimals and letter
   int          err_total, tests_run, cyc, i;
   localparam logic [5:0] FC [0:26] = '{6'h01, 6'h02, 6'h03, 6'h05, 6'h06, 6'h07, 6'h08,
      6'h09, 6'h0A, 6'h0B, 6'h0C, 6'h0E, 6'h10, 6'h11, 6'h12, 6'h13, 6'h14, 6'h15, 6'h16,
      6'h17, 6'h18, 6'h19, 6'h1A, 6'h1B, 6'h1C, 6'h20, 6'h22};
   localparam logic [15:0] AD [0:8] = '{16'h2102, 16'h2103, 16'h2104, 16'h2106, 16'h2108,
      16'h2109, 16'h210A, 16'h2116, 16'h2117};
   dsm_monitor_regs i_dut (
      .clk(clk), .arst_n(arst_n), .rd_start(rd_start), .rd_req(rd_req), .rd_addr(rd_addr),
      .wr_req(wr_req), .rd_valid(rd_valid), .rd_data(rd_data), .rd_illegal(rd_illegal),
      .wr_refused(wr_refused), .overcurrent_fault(flt[0]), .overvoltage_fault(flt[1]),
      .stage_overheat_fault(flt[2]), .overload_fault(flt[3]), .overload1_fault(flt[4]),
      .overload2_fault(flt[5]), .external_fault(flt[6]), .accel_overcurrent(flt[7]),
      .decel_overcurrent(flt[8]), .steady_overcurrent(flt[9]), .ground_fault(flt[10]),
      .phase_loss(flt[11]), .ramp_tune_failure(flt[12]), .sw_protect_active(flt[13]),
      .pb_write_failure(flt[14]), .pb_read_failure(flt[15]), .hw_protect_failure(flt[19:16]),
      .u_phase_error(flt[20]), .v_phase_error(flt[21]), .w_phase_error(flt[22]),
      .dc_bus_error(flt[23]), .phase_check_overheat(flt[24]), .loop_input_error(flt[25]),
      .thermistor_overheat(flt[26]), .run_state(st[1:0]), .jog_active(st[2]),
      .direction_state(st[4:3]), .freq_from_comm(st[8]), .freq_from_analog(st[9]),
      .oper_from_comm(st[10]), .freq_command(m[0]), .output_frequency(m[1]),
      .output_current(m[2]), .pid_feedback(m[3]), .bus_voltage(m[4]), .output_voltage(m[5]),
      .power_stage_temp(m[6]), .user_display_value(m[7]),
      .user_display_decimals(m[8][15:8]), .user_display_letter(m[8][7:0]));
   dsm_master_model i_mst (.clk(clk), .rd_start(rd_start), .rd_req(rd_req),
      .rd_addr(rd_addr), .wr_req(wr_req), .rd_valid(rd_valid), .rd_data(rd_data),
      .rd_illegal(rd_illegal), .wr_refused(wr_refused));
   // Free-running clock, 4 ns
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Verdict and end of run
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // One read with answer, flag and data compared
   task automatic rdc(input logic [15:0] a, input logic [15:0] e, input logic ie);
      logic [15:0] d;
      logic        il, ok;
      i_mst.read(a, d, il, ok);
      `DSM_CHK("valid", 1'b1, ok)
      `DSM_CHK("illegal", ie, il)
      `DSM_CHK("data", e, d)
   endtask
   // Faults pass a synchroniser, so let them settle before a snapshot
   task automatic fault_rd(input logic [26:0] f, input logic [15:0] e);
      flt = f;
      repeat (4) @(negedge clk);
      i_mst.snap();
      rdc(16'h2100, e, 1'b0);
   endtask
   // Hang guard, well above the expected run length
   always @(posedge clk) begin
      cyc++;
      if (cyc == 4000) begin
         err_total++;
         print_verdict();
      end
   end
   initial begin
      flt = 27'h0000000;
      st = 11'h000;
      for (i = 0; i < 9; i++) m[i] = 16'h0000;
      arst_n = 1'b0;
      repeat (2) @(negedge clk);
      arst_n = 1'b1;
      repeat (3) @(negedge clk);
      for (i = 0; i < 27; i++) fault_rd(27'h1 << i, {10'h000, FC[i]});
      fault_rd(27'h7FFFFF0, 16'h0006);
      fault_rd(27'h0000000, 16'h0000);
      $display("fault code test done");
      for (i = 0; i < 4; i++) begin
         st = {~i[0], i[1], i[0], 3'h7, ~i[1:0], i[0], i[1:0]};
         i_mst.snap();
         rdc(16'h2101, {5'h00, st[10:8], 3'h0, st[4:0]}, 1'b0);
      end
      $display("status test done");
      for (i = 0; i < 9; i++) m[i] = 16'(16'h1357 * (i + 1));
      i_mst.snap();
      for (i = 0; i < 9; i++) m[i] = ~m[i]; // Sources move after the snapshot
      for (i = 0; i < 9; i++) rdc(AD[i], ~m[i], 1'b0);
      $display("monitor word test done");
      rdc(16'h2105, 16'h0000, 1'b0);
      rdc(16'h2107, 16'h0000, 1'b0);
      rdc(16'h210B, 16'h0000, 1'b1);
      rdc(16'h2118, 16'h0000, 1'b1);
      i_mst.poke(rf);
      `DSM_CHK("refused", 1'b1, rf)
      rdc(AD[0], ~m[0], 1'b0);
      $display("address test done");
      print_verdict();
   end
endmodule
